// ### core/buck_softstart_fault_sequencer.sv
// soft-start, output-ok and hiccup fault sequencer of a buck switcher
`timescale 1ns/100ps
`include "buck_seq_cfg.svh"

// Behaviour
// RULE1 - turn-on low: regulator off, no switching
// RULE2 - turn-on low, supply ok: discharge output
// RULE3 - turn-on high (>=1V comparator) enables switcher
// RULE4 - valley overcurrent holds low side, blocks on-time
// RULE5 - soft-start: on-time when feedback below 40% ramp
// RULE6 - regulation: ramp above 1.5V, feedback at 600mV
// RULE7 - output-ok high after ramp 67%, in regulation
// RULE8 - after start-up delay pull ramp to supply
// RULE9 - pre-bias: gates inhibited until ramp meets feedback
// RULE10 - soft-start: low side off at zero current
// RULE11 - output-ok low 10% under, 2% hysteresis
// RULE12 - output-ok low above 720mV
// RULE13 - output-ok low while turn-on low, supply ok
// RULE14 - over-voltage guard armed when enabled, 5us filter
// RULE15 - over-voltage: low side high, stop, recovery
// RULE16 - restart: low side low about 30us
// RULE17 - eight cycles at 450mV: shut off, recover
// RULE18 - recovery counts 15 or 16 ramp cycles
// RULE19 - after count soft-start; persisting fault repeats
// RULE20 - over-voltage recovery low side high, else low
// RULE21 - feedback above over-voltage suspends ramp charging
// RULE22 - regulator faults get no hiccup restart
// RULE23 - lockout tri-states gates, clears latch on rise
// RULE24 - counter cleared at entry, 16 for ov/ot
module buck_softstart_fault_sequencer
  import buck_seq_pkg::*;
#(
  parameter int OV_FILTER_CYC  = `OV_FILTER_CYC,
  parameter int REINIT_LOW_CYC = `REINIT_LOW_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // control and supply pins (asynchronous)
  input  wire logic switcher_turn_on_i,
  input  wire logic supply_above_rise_i,
  input  wire logic supply_above_fall_i,
  input  wire logic over_temp_i,
  input  wire logic ldo_fault_i,
  // analog comparators (asynchronous)
  input  wire logic fb_below_scaled_ramp_i,
  input  wire logic fb_below_reg_i,
  input  wire logic fb_below_ok_fall_i,
  input  wire logic fb_above_ok_rise_i,
  input  wire logic fb_above_ov_i,
  input  wire logic fb_below_uv_i,
  input  wire logic ramp_above_reg_i,
  input  wire logic ramp_above_ok_i,
  input  wire logic ramp_at_zero_i,
  input  wire logic valley_limit_sense_i,
  input  wire logic zero_current_i,
  // on-time generator
  input  wire logic on_time_done_i,
  // gate and ramp controls
  output logic      high_side_gate_o,
  output logic      low_side_gate_o,
  output logic      gates_enable_o,
  output logic      ramp_charge_o,
  output logic      ramp_discharge_o,
  output logic      ramp_pull_up_o,
  output logic      output_discharge_o,
  output logic      on_time_start_o,
  // open-drain output-ok flag
  output logic      output_ok_flag_o,
  output logic      output_ok_flag_oe_o
);
  localparam int N_IN = 16;
  logic [N_IN-1:0] pins;
  logic [N_IN-1:0] sync;

  assign pins = {switcher_turn_on_i, supply_above_rise_i, supply_above_fall_i, over_temp_i,
                 ldo_fault_i, fb_below_scaled_ramp_i, fb_below_reg_i, fb_below_ok_fall_i,
                 fb_above_ok_rise_i, fb_above_ov_i, fb_below_uv_i, ramp_above_reg_i,
                 ramp_above_ok_i, ramp_at_zero_i, valley_limit_sense_i, zero_current_i};

  pin_sync #(.WIDTH(N_IN)) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pin_i   (pins),
    .level_o (sync)
  );

  logic en, sup_rise, sup_fall, ot, ldo_flt, fb_lt_ss, fb_lt_reg, fb_lt_okf;
  logic fb_gt_okr, fb_gt_ov, fb_lt_uv, ss_gt_reg, ss_gt_ok, ss_zero, valley_limit_sense, zc;
  assign {en, sup_rise, sup_fall, ot, ldo_flt, fb_lt_ss, fb_lt_reg, fb_lt_okf,
          fb_gt_okr, fb_gt_ov, fb_lt_uv, ss_gt_reg, ss_gt_ok, ss_zero, valley_limit_sense, zc} = sync;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  seq_state_type   state, next_state;
  fault_cause_type cause, next_cause;
  logic [4:0]  hic_cnt, next_hic_cnt;
  logic        ramp_phase, next_ramp_phase;
  logic [31:0] tmr, next_tmr;
  logic [31:0] ov_cnt, next_ov_cnt;
  logic [3:0]  uv_cnt, next_uv_cnt;
  logic        hs_on, next_hs_on;
  logic        ls_on, next_ls_on;
  logic        pg, next_pg;
  logic        started, next_started;
  logic        ov_trip;
  logic        cycle_end;

  function automatic logic [4:0] hiccup_limit(input fault_cause_type c);
    hiccup_limit = (c == CAUSE_OV || c == CAUSE_OT) ? `HICCUP_COUNT_OV_OT
                                                   : `HICCUP_COUNT_NORMAL; // RULE24
  endfunction : hiccup_limit

  assign ov_trip   = (ov_cnt >= 32'(OV_FILTER_CYC)); // RULE14
  assign cycle_end = hs_on && on_time_done_i;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_cause      = cause;
    next_hic_cnt    = hic_cnt;
    next_ramp_phase = ramp_phase;
    next_tmr        = tmr;
    next_ov_cnt     = ov_cnt;
    next_uv_cnt     = uv_cnt;
    next_hs_on      = hs_on;
    next_ls_on      = ls_on;
    next_pg         = pg;
    next_started    = started;
    // over-voltage filter, armed only while enabled
    if (en && fb_gt_ov && state != ST_FAULT && state != ST_LOCKOUT) begin
      if (!ov_trip) next_ov_cnt = ov_cnt + 32'h1; // RULE14
    end else begin
      next_ov_cnt = 32'h0;
    end
    // under-voltage counted per switching cycle
    if (state == ST_RUN && cycle_end) begin
      next_uv_cnt = fb_lt_uv ? uv_cnt + 4'h1 : 4'h0; // RULE17
    end else if (state != ST_RUN) begin
      next_uv_cnt = 4'h0;
    end
    // output-ok window with hysteresis
    if (state != ST_RUN || !en || fb_gt_ov) begin
      next_pg = 1'b0; // RULE12 RULE13
    end else if (pg && fb_lt_okf) begin
      next_pg = 1'b0; // RULE11
    end else if (!pg && started && !fb_gt_okr && !fb_lt_okf) begin
      next_pg = 1'b1; // RULE11
    end
    unique case (state)
      ST_LOCKOUT: begin
        next_hs_on = 1'b0;
        next_ls_on = 1'b0;
        next_cause = CAUSE_NONE; // RULE23
        next_hic_cnt = 5'h0; // RULE24
        next_started = 1'b0;
        if (sup_rise) next_state = ST_OFF; // RULE23
      end
      ST_OFF: begin
        next_hs_on = 1'b0; // RULE1
        next_ls_on = 1'b0;
        next_started = 1'b0;
        next_tmr = 32'h0;
        if (en) next_state = ST_REINIT; // RULE3
      end
      ST_REINIT: begin
        next_ls_on = 1'b0; // RULE16
        next_hs_on = 1'b0;
        next_tmr = tmr + 32'h1;
        if (tmr + 32'h1 >= 32'(REINIT_LOW_CYC)) begin
          next_tmr   = 32'h0;
          next_state = ST_PREBIAS;
        end
      end
      ST_PREBIAS: begin
        if (fb_lt_ss) next_state = ST_SOFTSTART; // RULE9
        // a pre-bias above the trip point never meets the ramp, so act here
        if (ov_trip) begin
          next_state = ST_FAULT; // RULE14 RULE15
          next_cause = CAUSE_OV;
          next_ls_on = 1'b1;
          next_hic_cnt = 5'h0; // RULE24
          next_ramp_phase = 1'b0;
        end
      end
      ST_SOFTSTART, ST_RUN: begin
        if (hs_on) begin
          if (on_time_done_i) begin
            next_hs_on = 1'b0;
            next_ls_on = 1'b1;
          end
        end else if (ls_on && valley_limit_sense) begin
          next_ls_on = 1'b1; // RULE4
        end else if (fb_lt_ss || (state == ST_RUN && fb_lt_reg)) begin
          next_hs_on = 1'b1; // RULE5
          next_ls_on = 1'b0;
        end else if (state == ST_SOFTSTART && ls_on && zc) begin
          next_ls_on = 1'b0; // RULE10
        end
        if (state == ST_SOFTSTART && ss_gt_reg && !fb_lt_reg) begin
          next_state = ST_RUN; // RULE6
        end
        if (state == ST_RUN && ss_gt_ok) next_started = 1'b1; // RULE7 RULE8
        if (ov_trip) begin
          next_state = ST_FAULT; // RULE15
          next_cause = CAUSE_OV;
          next_hs_on = 1'b0;
          next_ls_on = 1'b1;
          next_hic_cnt = 5'h0; // RULE24
          next_ramp_phase = 1'b0;
        end else if (ot || uv_cnt >= `UV_CYCLE_LIMIT ||
                     (state == ST_SOFTSTART && ss_gt_ok && !started)) begin
          next_state = ST_FAULT; // RULE17 RULE19
          next_cause = ot ? CAUSE_OT : CAUSE_UV;
          next_hs_on = 1'b0;
          next_ls_on = 1'b0;
          next_hic_cnt = 5'h0; // RULE24
          next_ramp_phase = 1'b0;
        end
      end
      ST_FAULT: begin
        next_hs_on = 1'b0;
        next_ls_on = (cause == CAUSE_OV); // RULE20
        if (cause == CAUSE_OV && fb_gt_ov) begin
          next_ramp_phase = 1'b0; // RULE21
        end else if (!ramp_phase && ss_zero) begin
          next_ramp_phase = 1'b1; // RULE18
        end else if (ramp_phase && ss_gt_ok) begin
          next_ramp_phase = 1'b0;
          next_hic_cnt = hic_cnt + 5'h1; // RULE18
          if (hic_cnt + 5'h1 >= hiccup_limit(cause)) begin
            next_state = ST_REINIT; // RULE19
            next_tmr = 32'h0;
            next_started = 1'b0;
          end
        end
      end
      ST_LDO_FAULT: begin
        next_hs_on = 1'b0; // RULE22
        next_ls_on = 1'b0;
      end
    endcase
    // global overrides: lockout, regulator fault, turn-on low
    if (!sup_fall && state != ST_LOCKOUT) begin
      next_state = ST_LOCKOUT; // RULE23
      next_hs_on = 1'b0;
      next_ls_on = 1'b0;
    end else if (ldo_flt && state != ST_LOCKOUT) begin
      next_state = ST_LDO_FAULT; // RULE22
      next_hs_on = 1'b0;
      next_ls_on = 1'b0;
    end else if (!en && state != ST_LOCKOUT && state != ST_LDO_FAULT) begin
      next_state = ST_OFF; // RULE1
      next_hs_on = 1'b0;
      next_ls_on = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state      <= ST_LOCKOUT;
      cause      <= CAUSE_NONE;
      hic_cnt    <= 5'h0;
      ramp_phase <= 1'b0;
      tmr        <= 32'h0;
      ov_cnt     <= 32'h0;
      uv_cnt     <= 4'h0;
      hs_on      <= 1'b0;
      ls_on      <= 1'b0;
      pg         <= 1'b0;
      started    <= 1'b0;
    end else begin
      state      <= next_state;
      cause      <= next_cause;
      hic_cnt    <= next_hic_cnt;
      ramp_phase <= next_ramp_phase;
      tmr        <= next_tmr;
      ov_cnt     <= next_ov_cnt;
      uv_cnt     <= next_uv_cnt;
      hs_on      <= next_hs_on;
      ls_on      <= next_ls_on;
      pg         <= next_pg;
      started    <= next_started;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign high_side_gate_o    = hs_on;
  assign low_side_gate_o     = ls_on;
  assign gates_enable_o      = (state != ST_LOCKOUT); // RULE23
  assign ramp_charge_o       = (state == ST_SOFTSTART || state == ST_RUN ||
                                state == ST_PREBIAS ||
                                (state == ST_FAULT && ramp_phase));
  assign ramp_discharge_o    = (state == ST_OFF || state == ST_REINIT || state == ST_LOCKOUT ||
                                (state == ST_FAULT && !ramp_phase)); // RULE18 RULE21
  assign ramp_pull_up_o      = (state == ST_RUN) && started; // RULE8
  assign output_discharge_o  = (state == ST_OFF); // RULE2
  assign on_time_start_o     = !hs_on && next_hs_on;
  assign output_ok_flag_o    = 1'b0;
  assign output_ok_flag_oe_o = !pg; // RULE7 RULE15
endmodule : buck_softstart_fault_sequencer

// ### core/buck_seq_cfg.svh
// constants for the buck soft-start and fault sequencer
`ifndef BUCK_SEQ_CFG_SVH
`define BUCK_SEQ_CFG_SVH
`define CLK_PERIOD_NS        8
`define OV_FILTER_NS         5000
`define OV_FILTER_CYC        ((`OV_FILTER_NS) / (`CLK_PERIOD_NS))
`define REINIT_LOW_NS        30000
`define REINIT_LOW_CYC       ((`REINIT_LOW_NS + `CLK_PERIOD_NS - 1) / (`CLK_PERIOD_NS))
`define UV_CYCLE_LIMIT       4'h8
`define HICCUP_COUNT_NORMAL  5'h0F
`define HICCUP_COUNT_OV_OT   5'h10
`endif

// ### core/buck_seq_pkg.sv
// types for the buck soft-start and fault sequencer
package buck_seq_pkg;
  typedef enum logic [2:0] {
    ST_LOCKOUT  = 3'h0,
    ST_OFF      = 3'h1,
    ST_REINIT   = 3'h2,
    ST_PREBIAS  = 3'h3,
    ST_SOFTSTART= 3'h4,
    ST_RUN      = 3'h5,
    ST_FAULT    = 3'h6,
    ST_LDO_FAULT= 3'h7
  } seq_state_type;
  typedef enum logic [1:0] {
    CAUSE_NONE = 2'h0,
    CAUSE_UV   = 2'h1,
    CAUSE_OV   = 2'h2,
    CAUSE_OT   = 2'h3
  } fault_cause_type;
endpackage : buck_seq_pkg

// ### core/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // pins
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  always_comb begin
    next_level = level_o;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1  <= '0;
      stage2  <= '0;
      stage3  <= '0;
      level_o <= '0;
    end else begin
      stage1  <= pin_i;
      stage2  <= stage1;
      stage3  <= stage2;
      level_o <= next_level;
    end
  end
endmodule : pin_sync

// ### dv/buck_seq_asserts.sv
// port checks for the buck sequencer
`timescale 1ns/100ps
module buck_seq_asserts #(
  parameter int OV_FILTER_CYC  = 4,
  parameter int REINIT_LOW_CYC = 4
) (
  // clock, reset and pins
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic switcher_turn_on_i,
  input wire logic supply_above_fall_i,
  input wire logic ldo_fault_i,
  input wire logic fb_above_ov_i,
  input wire logic fb_below_ok_fall_i,
  input wire logic valley_limit_sense_i,
  // outputs
  input wire logic high_side_gate_o,
  input wire logic low_side_gate_o,
  input wire logic gates_enable_o,
  input wire logic output_discharge_o,
  input wire logic on_time_start_o,
  input wire logic output_ok_flag_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic en_ok;
  int   ov_cnt;
  int   next_ov_cnt;
  assign en_ok = switcher_turn_on_i && supply_above_fall_i && !ldo_fault_i;
  // ----
  // over-voltage dwell, saturating
  // ----
  always_comb begin
    next_ov_cnt = ov_cnt;
    if (!(fb_above_ov_i && en_ok)) next_ov_cnt = 0;
    else if (ov_cnt < OV_FILTER_CYC + 8) next_ov_cnt = ov_cnt + 1;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) ov_cnt <= 0;
    else ov_cnt <= next_ov_cnt;
  end
  sequence s_off_held;
    (!switcher_turn_on_i && supply_above_fall_i)[*8];
  endsequence
  a_tristate_gates:
    assert property ((!gates_enable_o)[*2] |-> !high_side_gate_o && !low_side_gate_o)
    else $error("gate on while tri-stated");
  a_off_no_switch:
    assert property (s_off_held |-> !high_side_gate_o && !on_time_start_o)
    else $error("switching while off");
  a_off_discharge:
    assert property (s_off_held |-> output_discharge_o) else $error("no discharge while off");
  a_off_flag:
    assert property (s_off_held |-> output_ok_flag_oe_o) else $error("flag released while off");
  a_valley_block:
    assert property ((valley_limit_sense_i && en_ok)[*8] |-> !on_time_start_o)
    else $error("on-time during overcurrent");
  a_flag_ov:
    assert property (fb_above_ov_i[*8] |-> output_ok_flag_oe_o) else $error("flag high over");
  a_flag_under:
    assert property (fb_below_ok_fall_i[*8] |-> output_ok_flag_oe_o) else $error("flag high under");
  a_ov_low_side:
    assert property (ov_cnt == OV_FILTER_CYC + 8 |-> low_side_gate_o && output_ok_flag_oe_o)
    else $error("over-voltage not acted on");
  a_start_pulse:
    assert property (on_time_start_o |=> high_side_gate_o && !on_time_start_o)
    else $error("on-time start not followed");
endmodule : buck_seq_asserts

bind buck_softstart_fault_sequencer buck_seq_asserts #(
  .OV_FILTER_CYC(OV_FILTER_CYC),
  .REINIT_LOW_CYC(REINIT_LOW_CYC)
) chk (.clk_i, .rst_b_i, .switcher_turn_on_i, .supply_above_fall_i, .ldo_fault_i,
  .fb_above_ov_i, .fb_below_ok_fall_i, .valley_limit_sense_i, .high_side_gate_o,
  .low_side_gate_o, .gates_enable_o, .output_discharge_o, .on_time_start_o,
  .output_ok_flag_oe_o);

// ### dv/buck_power_stage.sv
// behavioural power stage and soft-start capacitor
`timescale 1ns/100ps
module buck_power_stage #(
  parameter int REG_LVL = 200,
  parameter int OK_LVL  = 300,
  parameter int ON_CYC  = 4
) (
  // gate and ramp controls
  input  wire logic clk_i,
  input  wire logic high_side_gate_i,
  input  wire logic low_side_gate_i,
  input  wire logic ramp_charge_i,
  input  wire logic ramp_discharge_i,
  input  wire logic ramp_pull_up_i,
  // sensed levels
  output logic      ramp_above_reg_o,
  output logic      ramp_above_ok_o,
  output logic      ramp_at_zero_o,
  output logic      on_time_done_o,
  output logic      zero_current_o
);
  int ramp = 0;
  int hs_cnt = 0;
  int ls_cnt = 0;
  // capacitor charges one step a cycle, discharge is immediate
  always @(posedge clk_i) begin
    if (ramp_discharge_i) ramp <= 0;
    else if (ramp_pull_up_i) ramp <= OK_LVL + 50;
    else if (ramp_charge_i && ramp < OK_LVL + 50) ramp <= ramp + 1;
    hs_cnt <= high_side_gate_i ? hs_cnt + 1 : 0;
    ls_cnt <= low_side_gate_i ? ls_cnt + 1 : 0;
  end
  assign ramp_above_reg_o = ramp > REG_LVL;
  assign ramp_above_ok_o  = ramp >= OK_LVL;
  assign ramp_at_zero_o   = ramp == 0;
  assign on_time_done_o   = hs_cnt >= ON_CYC - 1;
  assign zero_current_o   = ls_cnt >= 40;
endmodule : buck_power_stage

// ### dv/tb_top.sv
// self-checking bench for the buck sequencer
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 0, rst_b_i = 0, switcher_turn_on_i = 0, sup = 1, over_temp_i = 0;
  logic ldo_fault_i = 0, fb_below_scaled_ramp_i = 0, fb_below_reg_i = 1;
  logic fb_below_ok_fall_i = 1, fb_above_ok_rise_i = 1, fb_above_ov_i = 0;
  logic fb_below_uv_i = 0, valley_limit_sense_i = 0;
  logic ramp_above_reg_i, ramp_above_ok_i, ramp_at_zero_i, zero_current_i, on_time_done_i;
  logic high_side_gate_o, low_side_gate_o, gates_enable_o, ramp_charge_o, ramp_discharge_o;
  logic ramp_pull_up_o, output_discharge_o, on_time_start_o, output_ok_flag_o;
  logic output_ok_flag_oe_o;
  int   err_count = 0, num_checks = 0, cyc = 0, n;
  bit   hit;
  buck_softstart_fault_sequencer #(.OV_FILTER_CYC(4), .REINIT_LOW_CYC(4)) DUT (.clk_i,
    .rst_b_i, .switcher_turn_on_i, .supply_above_rise_i(sup), .supply_above_fall_i(sup),
    .over_temp_i, .ldo_fault_i, .fb_below_scaled_ramp_i, .fb_below_reg_i,
    .fb_below_ok_fall_i, .fb_above_ok_rise_i, .fb_above_ov_i, .fb_below_uv_i,
    .ramp_above_reg_i, .ramp_above_ok_i, .ramp_at_zero_i, .valley_limit_sense_i,
    .zero_current_i, .on_time_done_i, .high_side_gate_o, .low_side_gate_o, .gates_enable_o,
    .ramp_charge_o, .ramp_discharge_o, .ramp_pull_up_o, .output_discharge_o,
    .on_time_start_o, .output_ok_flag_o, .output_ok_flag_oe_o);
  buck_power_stage stage (.clk_i, .high_side_gate_i(high_side_gate_o),
    .low_side_gate_i(low_side_gate_o), .ramp_charge_i(ramp_charge_o),
    .ramp_discharge_i(ramp_discharge_o), .ramp_pull_up_i(ramp_pull_up_o),
    .ramp_above_reg_o(ramp_above_reg_i), .ramp_above_ok_o(ramp_above_ok_i),
    .ramp_at_zero_o(ramp_at_zero_i), .on_time_done_o(on_time_done_i),
    .zero_current_o(zero_current_i));
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      stop_test();
    end
  end
  // ----
  // shared tasks
  // ----
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %b got %b", nm, exp, got);
    end
  endtask : chk
  task automatic chk_n(input string nm, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      err_count++;
      $display("mismatch %s exp %0d got %0d", nm, exp, got);
    end
  endtask : chk_n
  task automatic wait_ots(input int lim, output bit h);
    h = 0;
    repeat (lim) begin
      step(1);
      if (on_time_start_o === 1'b1) begin
        h = 1;
        return;
      end
    end
  endtask : wait_ots
  // counts charge cycles up to the restart on-time
  task automatic hiccup(input int exp, input logic ls);
    int   rises = 0;
    logic prev = ramp_above_ok_i;
    bit   bad = 0;
    bit   lo = 0;
    repeat (20000) begin
      step(1);
      if (on_time_start_o === 1'b1) break;
      if (ramp_above_ok_i && !prev) rises++;
      if (rises < exp && low_side_gate_o !== ls) bad = 1;
      if (rises == exp && low_side_gate_o === 1'b0) lo = 1;
      prev = ramp_above_ok_i;
    end
    chk_n("charge cycles", exp, rises);
    chk("recovery low side", 1'b0, bad);
    chk("restart low side low", 1'b1, lo);
  endtask : hiccup
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  // ----
  // scenarios
  // ----
  task automatic t_off();
    step(30);
    chk("high gate off", 1'b0, high_side_gate_o);
    chk("discharge", 1'b1, output_discharge_o);
    chk("flag pulled", 1'b1, output_ok_flag_oe_o);
    chk("flag pin low", 1'b0, output_ok_flag_o);
    chk("drivers enabled", 1'b1, gates_enable_o);
  endtask : t_off
  task automatic t_flag();
    {fb_below_ok_fall_i, fb_above_ok_rise_i} = 2'h3;
    step(10);
    chk("flag pulled under", 1'b1, output_ok_flag_oe_o);
    fb_below_ok_fall_i = 0;
    step(10);
    chk("flag hysteresis", 1'b1, output_ok_flag_oe_o);
    fb_above_ok_rise_i = 0;
    step(10);
    chk("flag re-released", 1'b0, output_ok_flag_oe_o);
  endtask : t_flag
  task automatic t_start();
    switcher_turn_on_i = 1;
    wait_ots(100, hit);
    chk("prebias hold", 1'b0, hit);
    fb_below_scaled_ramp_i = 1;
    wait_ots(400, hit);
    chk("soft-start on-time", 1'b1, hit);
    step(1);
    chk("high gate on", 1'b1, high_side_gate_o);
    chk("flag low in start", 1'b1, output_ok_flag_oe_o);
    {fb_below_reg_i, fb_below_ok_fall_i, fb_above_ok_rise_i, fb_below_scaled_ramp_i} = 4'h0;
    n = 0;
    while (output_ok_flag_oe_o !== 1'b0 && n < 2000) begin
      step(1);
      n++;
    end
    chk("flag released", 1'b0, output_ok_flag_oe_o);
    chk("ramp pulled up", 1'b1, ramp_pull_up_o);
  endtask : t_start
  task automatic t_valley();
    fb_below_reg_i = 1;
    wait_ots(200, hit);
    valley_limit_sense_i = 1;
    wait_ots(100, hit);
    chk("blocked on-time", 1'b0, hit);
    chk("low side held", 1'b1, low_side_gate_o);
    valley_limit_sense_i = 0;
    wait_ots(100, hit);
    chk("on-time resumes", 1'b1, hit);
  endtask : t_valley
  task automatic t_under();
    fb_below_uv_i = 1;
    n = 0;
    repeat (100) begin
      step(1);
      if (on_time_start_o === 1'b1) n++;
    end
    // the on-time already in flight ends low too and is the first of the eight
    chk_n("under on-times", 7, n);
    chk("gates low", 1'b0, high_side_gate_o | low_side_gate_o);
    fb_below_uv_i = 0;
    fb_below_scaled_ramp_i = 1;
    hiccup(15, 1'b0);
    {fb_below_reg_i, fb_below_scaled_ramp_i} = 2'h0;
  endtask : t_under
  task automatic t_over();
    fb_above_ov_i = 1;
    n = 0;
    step(16);
    chk("ov low side", 1'b1, low_side_gate_o);
    chk("ov flag", 1'b1, output_ok_flag_oe_o);
    repeat (1000) begin
      step(1);
      if (ramp_above_ok_i === 1'b1) n++;
    end
    chk_n("suspended charge", 0, n);
    chk("ov low side held", 1'b1, low_side_gate_o);
    chk("ramp held low", 1'b1, ramp_discharge_o);
    chk("no ramp charge", 1'b0, ramp_charge_o);
    fb_above_ov_i = 0;
    fb_below_scaled_ramp_i = 1;
    hiccup(16, 1'b1);
  endtask : t_over
  task automatic t_ldo();
    ldo_fault_i = 1;
    wait_ots(6000, hit);
    chk("no regulator restart", 1'b0, hit);
  endtask : t_ldo
  task automatic t_ot();
    over_temp_i = 1;
    step(8);
    chk("ot gates low", 1'b0, high_side_gate_o | low_side_gate_o);
    over_temp_i = 0;
    hiccup(16, 1'b0);
  endtask : t_ot
  task automatic t_lockout();
    {ldo_fault_i, sup} = 2'h0;
    step(10);
    chk("lockout tri-state", 1'b0, gates_enable_o);
    chk("lockout gates low", 1'b0, high_side_gate_o | low_side_gate_o);
    sup = 1;
    wait_ots(200, hit);
    chk("restart after lockout", 1'b1, hit);
    chk("drivers back on", 1'b1, gates_enable_o);
  endtask : t_lockout
  initial begin
    step(16);
    rst_b_i = 1;
    t_off();
    t_start();
    t_flag();
    t_valley();
    t_under();
    t_over();
    t_ot();
    t_ldo();
    t_lockout();
    stop_test();
  end
endmodule : tb_top
